// >>> hw/ebp_top.sv
/*
 Bridge pulse-width modulator with an AXI4-Lite register slave.
 Assumes aclk is the oscillator clock, one master transaction of each
 kind at a time, and external drivers on the four outputs.
*/
`timescale 1ns/1ns

// Overview of operation
// (RL1) Bridge bits and mode nibble pick behaviour
// (RL2) Control values buffered, loaded at period reset
// (RL3) Dead-band loaded at duty or period boundary
// (RL4) Output starts only after first timer reset
// (RL5) Period is (limit+1) times four times prescale
// (RL6) At period match: clear, set output, load duty; the code leaves the output clear when the new duty is zero
// (RL7) Postscaler only makes a separate update event
// (RL8) Duty is eight high bits plus two
// (RL9) Active time is duty times clock times prescale
// (RL10) Duty writes anytime, applied at period match
// (RL11) Active duty buffer read-only in modulator mode
// (RL12) Output clears when buffer matches extended timer
// (RL13) Duty above period keeps output active
// (RL14) Four configurations: single, half, forward, reverse
// (RL15) Single configuration acts as plain modulator
// (RL16) Prescale factors 1, 4 and 16 only
// (RL17) Four outputs, per-pair polarity selectable
// (RL18) Codes 1100-1111 select modulator and polarity
// (RL19) Code 0000 switches off and resets module
// (RL20) Unused outputs sit at inactive level
// (RL21) Bridge patterns follow duty, turn at boundary
module ebp_top
  import ebp_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write address channel
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  // Write data channel
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // Write response channel
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // Read address channel
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  // Read data channel
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Power stage outputs and their enables
  output logic bridge_out_a,
  output logic bridge_out_b,
  output logic bridge_out_c,
  output logic bridge_out_d,
  output logic [3:0] bridge_oe,
  // Slow update event from the postscaler
  output logic update_event
);

  // Bus handshake state
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic [ADDR_W-1:0] waddr_q; // Held write address
  logic [7:0] wbyte_q; // Held low write byte
  logic wlane_q; // Low byte lane enabled

  // Software registers
  logic [7:0] mode_q; // pwm_mode_control
  logic [7:0] duty_q; // duty_high_bits_write
  logic [7:0] period_q; // period_limit
  logic [7:0] tcfg_q; // Timer prescale, enable, postscale
  logic [6:0] dead_q; // deadband_delay as written
  logic [3:0] pindir_q; // pin_direction_bits, 1 is input

  // Modulator state
  logic [5:0] base_q; // Clock count inside one timer step
  logic [7:0] timer_q; // period_timer
  logic [7:0] dbuf_q; // duty_active_buffer
  logic [1:0] latch_q; // Two low duty bits in use
  logic [6:0] dead_act_q; // Dead-band value in use
  logic [6:0] db_cnt_q; // Dead-band countdown
  logic [3:0] post_cnt_q; // Postscaler count
  logic running_q, pwm_q, upd_q;
  ebp_cfg_s cfg_q; // Buffered shape and polarity
  logic [3:0] out_q;

  // Write decode
  logic wr_fire, wr_ok, wr_err;
  logic [ADDR_W-1:0] woff;
  assign wr_fire = !awready_q && !wready_q && !bvalid_q;
  assign woff = {waddr_q[ADDR_W-1:2], 2'h0};
  assign wr_ok = (woff <= ADDR_W'(OFS_STATUS));
  assign wr_err = wr_fire && !wr_ok;
  logic we_mode, we_duty, we_dbuf, we_period, we_tcfg, we_dead, we_pin;
  assign we_mode = wr_fire && wlane_q && woff == ADDR_W'(OFS_MODE);
  assign we_duty = wr_fire && wlane_q && woff == ADDR_W'(OFS_DUTY);
  assign we_dbuf = wr_fire && wlane_q && woff == ADDR_W'(OFS_DBUF);
  assign we_period = wr_fire && wlane_q && woff == ADDR_W'(OFS_PERIOD);
  assign we_tcfg = wr_fire && wlane_q && woff == ADDR_W'(OFS_TCFG);
  assign we_dead = wr_fire && wlane_q && woff == ADDR_W'(OFS_DEAD);
  assign we_pin = wr_fire && wlane_q && woff == ADDR_W'(OFS_PINDIR);

  // Mode decode
  logic mode_off, pwm_mode;
  assign mode_off = mode_q[MSEL_HI:MSEL_LO] == MSEL_OFF; // RL19
  assign pwm_mode = mode_q[MSEL_HI:MSEL_HI-1] == MSEL_PWM_TOP; // RL18

  // Prescale select; codes 2 and 3 both mean sixteen
  logic [1:0] presc;
  logic [5:0] base_last;
  assign presc = tcfg_q[PRESC_LO+1:PRESC_LO];
  assign base_last = (presc == PRESC_1) ? BASE_LAST_1 :
                     (presc == PRESC_4) ? BASE_LAST_4 : BASE_LAST_16; // RL16

  // Timer stepping and period boundary
  logic tmr_run, tick, boundary, load;
  assign tmr_run = tcfg_q[TON_BIT] && !mode_off;
  assign tick = tmr_run && base_q == base_last; // RL5
  assign boundary = tick && timer_q == period_q; // RL6
  assign load = boundary && pwm_mode;

  // Duty compare against the count that the coming edge shows, so the
  // waveform drops on the edge that reaches the duty and not one clock late
  logic [9:0] duty_next, duty_buf, tmr_ext;
  logic [5:0] base_nxt; // Base counter after this edge
  logic [7:0] timer_nxt; // Period timer after this edge
  logic [1:0] sub; // Quarter-step bits after this edge
  logic match;
  assign base_nxt = (!tmr_run || tick) ? 6'h00 : base_q + 6'h01;
  assign timer_nxt = boundary ? 8'h00 : tick ? timer_q + 8'h01 : timer_q;
  // Quarter-step bits: Q clock or the top prescaler bits
  assign sub = (presc == PRESC_1) ? base_nxt[1:0] :
               (presc == PRESC_4) ? base_nxt[3:2] : base_nxt[5:4]; // RL12
  assign duty_next = {duty_q, mode_q[DLSB_HI:DLSB_LO]}; // RL8
  assign duty_buf = {dbuf_q, latch_q};
  assign tmr_ext = {timer_nxt, sub};
  assign match = duty_buf == tmr_ext; // RL9 RL12

  // Raw waveform next value
  logic pwm_d;
  assign pwm_d = !pwm_mode ? 1'b0 :
                 load ? (duty_next != 10'h000) : // RL6
                 match ? 1'b0 : pwm_q; // RL9 RL13

  // Dead-band: hold off the turning-on output after each edge
  logic settled;
  assign settled = db_cnt_q == 7'h00;

  // Logical activity per output, then polarity
  logic [3:0] act, inact;
  always_comb begin
    act = 4'h0;
    if (running_q) begin
      case (cfg_q.bridge) // RL14
        BR_SINGLE: act[0] = pwm_q; // RL15
        BR_HALF: begin
          act[0] = pwm_q && settled; // RL21
          act[1] = !pwm_q && settled;
        end
        BR_FULL_FWD: begin
          act[0] = 1'b1;
          act[3] = pwm_q; // RL21
        end
        BR_FULL_REV: begin
          act[2] = 1'b1;
          act[1] = pwm_q; // RL21
        end
        default: act = 4'h0;
      endcase
    end
  end
  // Unused outputs fall to inactive through act being zero
  assign inact = {cfg_q.pol_bd_low, cfg_q.pol_ac_low,
                  cfg_q.pol_bd_low, cfg_q.pol_ac_low}; // RL17 RL20

  // Read mux; status shows live timer and waveform state
  logic [ADDR_W-1:0] roff;
  logic [31:0] rd_val;
  logic rd_ok;
  assign roff = {araddr[ADDR_W-1:2], 2'h0};
  assign rd_ok = roff <= ADDR_W'(OFS_STATUS);
  assign rd_val =
    roff == ADDR_W'(OFS_MODE) ? {24'h0, mode_q} :
    roff == ADDR_W'(OFS_DUTY) ? {24'h0, duty_q} :
    roff == ADDR_W'(OFS_DBUF) ? {24'h0, dbuf_q} :
    roff == ADDR_W'(OFS_PERIOD) ? {24'h0, period_q} :
    roff == ADDR_W'(OFS_TCFG) ? {24'h0, tcfg_q} :
    roff == ADDR_W'(OFS_DEAD) ? {25'h0, dead_q} :
    roff == ADDR_W'(OFS_PINDIR) ? {28'h0, pindir_q} :
    roff == ADDR_W'(OFS_STATUS) ? {22'h0, running_q, pwm_q, timer_q} :
    32'h0;

  // Write address and data are taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      waddr_q <= '0;
      wbyte_q <= 8'h00;
      wlane_q <= 1'b0;
    end else begin
      if (awvalid && awready_q) begin
        awready_q <= 1'b0;
        waddr_q <= awaddr;
      end else if (bvalid_q && bready) begin
        awready_q <= 1'b1;
      end
      if (wvalid && wready_q) begin
        wready_q <= 1'b0;
        wbyte_q <= wdata[7:0];
        wlane_q <= wstrb[0];
      end else if (bvalid_q && bready) begin
        wready_q <= 1'b1;
      end
    end
  end

  // Write response one cycle after both halves are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_err ? RESP_SLVERR : RESP_OKAY;
    end else if (bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Read answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= RESP_OKAY;
    end else if (arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_val;
      rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && rready) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // Software registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q <= RST_MODE;
      duty_q <= RST_DUTY;
      period_q <= RST_PERIOD;
      tcfg_q <= RST_TCFG;
      dead_q <= RST_DEAD;
      pindir_q <= RST_PINDIR;
    end else begin
      if (we_mode) mode_q <= wbyte_q; // RL1
      if (we_duty) duty_q <= wbyte_q; // RL10
      if (we_period) period_q <= wbyte_q;
      if (we_tcfg) tcfg_q <= wbyte_q;
      if (we_dead) dead_q <= wbyte_q[6:0];
      if (we_pin) pindir_q <= wbyte_q[3:0];
    end
  end

  // Base counter and period timer
  always_ff @(posedge aclk) begin
    if (!aresetn || !tmr_run) begin
      base_q <= 6'h00;
    end else begin
      base_q <= tick ? 6'h00 : base_q + 6'h01;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || mode_off) begin
      timer_q <= 8'h00; // RL19
    end else if (boundary) begin
      timer_q <= 8'h00; // RL6
    end else if (tick) begin
      timer_q <= timer_q + 8'h01;
    end
  end

  // Active duty buffer, loaded at the period boundary; software writes it only outside modulator mode
  always_ff @(posedge aclk) begin
    if (!aresetn || mode_off) begin
      dbuf_q <= 8'h00;
      latch_q <= 2'h0;
    end else if (load) begin
      dbuf_q <= duty_q; // RL6 RL10
      latch_q <= mode_q[DLSB_HI:DLSB_LO];
    end else if (we_dbuf && !pwm_mode) begin
      dbuf_q <= wbyte_q; // RL11
    end
  end

  // Shape and polarity change only at a period boundary, and clear when switched off
  always_ff @(posedge aclk) begin
    if (!aresetn || mode_off) begin
      cfg_q <= '0;
    end else if (load) begin
      cfg_q.bridge <= ebp_bridge_e'(mode_q[BRIDGE_HI:BRIDGE_LO]); // RL2 RL21
      cfg_q.pol_ac_low <= mode_q[MSEL_LO+1]; // RL18
      cfg_q.pol_bd_low <= mode_q[MSEL_LO];
    end
  end

  // Start waits for the first timer reset after enabling
  always_ff @(posedge aclk) begin
    if (!aresetn || !pwm_mode) begin
      running_q <= 1'b0;
    end else if (load) begin
      running_q <= 1'b1; // RL4
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwm_q <= 1'b0;
    end else begin
      pwm_q <= pwm_d;
    end
  end

  // Dead-band value in use: first of duty or period boundary
  always_ff @(posedge aclk) begin
    if (!aresetn || mode_off) begin
      dead_act_q <= RST_DEAD;
    end else if (load || (match && pwm_q)) begin
      dead_act_q <= dead_q; // RL3
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || mode_off) begin
      db_cnt_q <= 7'h00;
    end else if (pwm_d != pwm_q) begin
      db_cnt_q <= dead_act_q;
    end else if (!settled) begin
      db_cnt_q <= db_cnt_q - 7'h01;
    end
  end

  // Postscaler: counts boundaries, never touches the period
  always_ff @(posedge aclk) begin
    if (!aresetn || mode_off) begin
      post_cnt_q <= 4'h0;
      upd_q <= 1'b0;
    end else if (boundary) begin
      upd_q <= post_cnt_q == tcfg_q[POST_LO+3:POST_LO]; // RL7
      post_cnt_q <= (post_cnt_q == tcfg_q[POST_LO+3:POST_LO]) ?
                    4'h0 : post_cnt_q + 4'h1;
    end else begin
      upd_q <= 1'b0;
    end
  end

  // Registered pins; enables follow the direction bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_q <= 4'h0;
    end else begin
      out_q <= act ^ inact; // RL17
    end
  end

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign {bridge_out_d, bridge_out_c, bridge_out_b, bridge_out_a} = out_q;
  assign bridge_oe = ~pindir_q;
  assign update_event = upd_q;

  // Checks kept beside the logic
  a_timer_clear: assert property (@(posedge aclk) disable iff (!aresetn) // RL6
    boundary |=> timer_q == 8'h00) else $error("timer not cleared");
  a_zero_duty: assert property (@(posedge aclk) disable iff (!aresetn) // RL6
    load && duty_next == 10'h000 |=> !pwm_q) else $error("zero duty set");
  a_duty_load: assert property (@(posedge aclk) disable iff (!aresetn) // RL10
    load |=> duty_buf == $past(duty_next)) else $error("duty not loaded");
  a_dbuf_ro: assert property (@(posedge aclk) disable iff (!aresetn) // RL11
    we_dbuf && pwm_mode && !load |=> $stable(dbuf_q)) else $error("buffer written");
  a_off_reset: assert property (@(posedge aclk) disable iff (!aresetn) // RL19
    mode_off |=> timer_q == 8'h00 && !running_q && !pwm_q) else $error("off not reset");
  a_tick_gap: assert property (@(posedge aclk) disable iff (!aresetn) // RL5
    tick |=> !tick [*3]) else $error("timer step too fast");
  a_long_duty: assert property (@(posedge aclk) disable iff (!aresetn) // RL13
    pwm_q && pwm_mode && !load && timer_q <= period_q &&
    duty_buf > {period_q, 2'h3} |=> pwm_q) else $error("long duty cleared");
  a_cfg_hold: assert property (@(posedge aclk) disable iff (!aresetn) // RL21
    !load && !mode_off |=> $stable(cfg_q)) else $error("shape changed midway");
  a_start_wait: assert property (@(posedge aclk) disable iff (!aresetn) // RL4
    !running_q && !load |=> !running_q ##1 out_q == $past(inact, 2))
    else $error("output started early");
  a_unused_idle: assert property (@(posedge aclk) disable iff (!aresetn) // RL20
    cfg_q.bridge == BR_SINGLE |=> bridge_out_b == $past(cfg_q.pol_bd_low))
    else $error("unused output active");
  a_bresp_next: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire |=> bvalid_q ##0 (bvalid_q [*1])) else $error("no write answer");

endmodule

// >>> hw/ebp_pkg.sv
/*
 Shared constants and types for the bridge pulse-width modulator.
 Assumes a 32-bit AXI4-Lite bus with one register per aligned word.
*/
package ebp_pkg;
  // Byte offsets of the registers
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_DUTY = 8'h04;
  localparam logic [7:0] OFS_DBUF = 8'h08;
  localparam logic [7:0] OFS_PERIOD = 8'h0c;
  localparam logic [7:0] OFS_TCFG = 8'h10;
  localparam logic [7:0] OFS_DEAD = 8'h14;
  localparam logic [7:0] OFS_PINDIR = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;
  // Mode control fields
  localparam int BRIDGE_HI = 7;
  localparam int BRIDGE_LO = 6;
  localparam int DLSB_HI = 5;
  localparam int DLSB_LO = 4;
  localparam int MSEL_HI = 3;
  localparam int MSEL_LO = 0;
  localparam logic [3:0] MSEL_OFF = 4'h0;
  localparam logic [1:0] MSEL_PWM_TOP = 2'h3;
  // Timer configuration fields
  localparam int PRESC_LO = 0;
  localparam int TON_BIT = 2;
  localparam int POST_LO = 3;
  localparam logic [1:0] PRESC_1 = 2'h0;
  localparam logic [1:0] PRESC_4 = 2'h1;
  // Base counter end values: four clocks times the prescale factor, less one
  localparam logic [5:0] BASE_LAST_1 = 6'h03;
  localparam logic [5:0] BASE_LAST_4 = 6'h0f;
  localparam logic [5:0] BASE_LAST_16 = 6'h3f;
  // Reset values
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [7:0] RST_DUTY = 8'h00;
  localparam logic [7:0] RST_PERIOD = 8'hff;
  localparam logic [7:0] RST_TCFG = 8'h00;
  localparam logic [6:0] RST_DEAD = 7'h00;
  localparam logic [3:0] RST_PINDIR = 4'hf;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Clock
  localparam int CLK_PERIOD_NS = 50;

  // Output configuration, in bridge-bit code order
  typedef enum logic [1:0] {
    BR_SINGLE,
    BR_HALF,
    BR_FULL_FWD,
    BR_FULL_REV
  } ebp_bridge_e;

  // Buffered output shape
  typedef struct packed {
    ebp_bridge_e bridge;
    logic pol_ac_low;
    logic pol_bd_low;
  } ebp_cfg_s;
endpackage

// >>> testbench/ebp_drv_model.sv
/*
 Model of the power stage drivers on the four modulator outputs.
 Assumes the drivers sample one selected line per aclk and have pull-down inputs.
*/
`timescale 1ns/1ns

module ebp_drv_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Lines from the modulator
  input wire logic [3:0] pins,
  input wire logic [3:0] oe,
  input wire logic [1:0] sel,
  // Measured waveform of the selected line
  output logic [15:0] hi_len,
  output logic [15:0] per_len,
  output logic [15:0] rise_cnt
);
  logic [15:0] cnt; // Cycles since last rising edge
  logic prev; // Line level one clock back
  wire logic [3:0] line = pins & oe; // Released lines fall to the pull-down
  wire logic lvl = line[sel];

  // Edge timing of the selected line, measured in clocks
  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= 16'h0000;
      prev <= 1'b0;
      hi_len <= 16'h0000;
      per_len <= 16'h0000;
      rise_cnt <= 16'h0000;
    end else begin
      prev <= lvl;
      cnt <= cnt + 16'h0001;
      if (lvl && !prev) begin
        // Period counted from rise to rise
        per_len <= cnt + 16'h0001;
        cnt <= 16'h0000;
        rise_cnt <= rise_cnt + 16'h0001;
      end
      if (!lvl && prev) begin
        hi_len <= cnt + 16'h0001;
      end
    end
  end
endmodule

// >>> testbench/ebp_top_tb.sv
/*
 Self-checking bench for the bridge modulator: AXI4-Lite master tasks,
 one task per scenario. Assumes the register map of the shared package.
*/
`timescale 1ns/1ns

module ebp_top_tb;
  import ebp_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, bridge_oe;
  logic [1:0] bresp, rresp, sel;
  logic awready, wready, bvalid, arready, rvalid, update_event;
  logic out_a, out_b, out_c, out_d;
  logic [15:0] hi_len, per_len, rise_cnt;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;
  logic [1:0] rsp;
  logic [31:0] rd;

  ebp_top i_ebp_top (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .bridge_out_a(out_a), .bridge_out_b(out_b),
    .bridge_out_c(out_c), .bridge_out_d(out_d), .bridge_oe(bridge_oe),
    .update_event(update_event));
  ebp_drv_model i_ebp_drv_model (.aclk(aclk), .aresetn(aresetn),
    .pins({out_d, out_c, out_b, out_a}), .oe(bridge_oe), .sel(sel), .hi_len(hi_len),
    .per_len(per_len), .rise_cnt(rise_cnt));

  // Clock at 20 MHz
  initial begin
    aclk = 1'b0;
    forever #(CLK_PERIOD_NS / 2) aclk = ~aclk;
  end

  // Hang guard, far above the thousand or so cycles the tests need
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch = n_mismatch + 1;
      results();
    end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Compare one value, widened to 32 bits
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count = check_count + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Write with address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        done = 1'b1;
      end
    end
    @(posedge aclk);
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        done = 1'b1;
      end
    end
    @(posedge aclk);
  endtask

  // Write and expect OKAY
  task automatic wok(input logic [7:0] a, input logic [7:0] d);
    wr(a, {24'h000000, d}, rsp);
    chk(rsp, RESP_OKAY);
  endtask

  // Let three rising edges pass on the chosen line, then judge its timing
  task automatic meas(input logic [1:0] s, input logic [15:0] hi, input logic [15:0] per);
    logic [15:0] start;
    sel <= s;
    @(posedge aclk);
    start = rise_cnt;
    while (rise_cnt < start + 16'h0003) @(posedge aclk);
    chk(hi_len, hi);
    chk(per_len, per);
  endtask

  task automatic t_reset();
    rd_reg(OFS_MODE, rd, rsp);
    chk(rd, 32'h00000000);
    rd_reg(OFS_PERIOD, rd, rsp);
    chk(rd, 32'h000000ff);
    rd_reg(OFS_PINDIR, rd, rsp);
    chk(rd, 32'h0000000f);
    chk(bridge_oe, 32'h00000000);
    rd_reg(8'h20, rd, rsp);
    chk({rsp, rd}, {RESP_SLVERR, 32'h00000000});
    wr(8'h20, 32'h000000ff, rsp);
    chk(rsp, RESP_SLVERR);
    wok(OFS_PINDIR, 8'h00);
    chk(bridge_oe, 32'h0000000f);
    $display("test reset done");
  endtask

  task automatic t_presc();
    wok(OFS_PERIOD, 8'h01);
    wok(OFS_DUTY, 8'h00);
    wok(OFS_TCFG, 8'h04);
    wok(OFS_MODE, 8'h2c);
    meas(2'h0, 16'd2, 16'd8);
    wok(OFS_DUTY, 8'h01);
    wok(OFS_MODE, 8'h1c);
    wok(OFS_TCFG, 8'h05);
    meas(2'h0, 16'd20, 16'd32);
    wok(OFS_DBUF, 8'haa);
    rd_reg(OFS_DBUF, rd, rsp);
    chk(rd, 32'h00000001);
    wok(OFS_TCFG, 8'h06);
    meas(2'h0, 16'd80, 16'd128);
    $display("test prescale done");
  endtask

  task automatic t_pol();
    wok(OFS_TCFG, 8'h04);
    wok(OFS_DUTY, 8'h00);
    wok(OFS_MODE, 8'h2f);
    meas(2'h0, 16'd6, 16'd8);
    chk({out_d, out_c, out_b}, 32'h00000007);
    $display("test polarity done");
  endtask

  // Half bridge, one clock of dead band, b/d active-low, event every 2nd period
  task automatic t_half();
    int n;
    n = 0;
    wok(OFS_TCFG, 8'h0c);
    wok(OFS_DUTY, 8'h01);
    wok(OFS_DEAD, 8'h01);
    wok(OFS_MODE, 8'h6d);
    meas(2'h0, 16'd5, 16'd8);
    meas(2'h1, 16'd7, 16'd8);
    chk({out_d, out_c}, 32'h00000002);
    repeat (64) begin
      @(posedge aclk);
      if (update_event === 1'b1) n = n + 1;
    end
    chk(n, 32'd4);
    wok(OFS_DUTY, 8'h00);
    $display("test half bridge done");
  endtask

  // Full bridge: one line held active, one following the duty wave
  task automatic t_bridge(input logic [7:0] m, input logic [1:0] s, input logic [3:0] rest);
    wok(OFS_MODE, m);
    meas(s, 16'd2, 16'd8);
    chk({out_d, out_c, out_b, out_a} & ~(4'h1 << s), rest);
    $display("test bridge done");
  endtask

  task automatic t_full_duty();
    int n;
    n = 0;
    wok(OFS_DUTY, 8'hff);
    wok(OFS_MODE, 8'h3c);
    repeat (20) @(posedge aclk);
    repeat (40) begin
      @(posedge aclk);
      if (out_a === 1'b1) n = n + 1;
    end
    chk(n, 32'd40);
    wok(OFS_MODE, 8'h00);
    repeat (3) @(posedge aclk);
    chk({out_d, out_c, out_b, out_a}, 32'h00000000);
    rd_reg(OFS_STATUS, rd, rsp);
    chk(rd[9], 32'h00000000);
    $display("test full duty and off done");
  endtask

  initial begin
    aresetn = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h00000000;
    wstrb = 4'hf;
    sel = 2'h0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_presc();
    t_pol();
    t_half();
    t_bridge(8'hac, 2'h3, 4'h1);
    t_bridge(8'hec, 2'h1, 4'h4);
    t_full_duty();
    results();
  end
endmodule
